//--- bench/test_ldtx_config_regs.sv
// Self-checking bench for the TX configuration register bank
`timescale 1ns/100ps
module test_ldtx_config_regs;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_dat = 32'h00000000;
  logic [7:0] meas = 8'h00;
  logic [1:0] pd_rng = 2'h0;
  logic [31:0] rdat;
  logic ack, leg, mode, dly, edge_r, sgn, dpd, dbm, lb_en, drive_on, fault, irq;
  logic [7:0] swing, thr;
  logic [3:0] strength;
  logic [6:0] mag;
  logic [9:0] bias;
  ldtx_pkg::ldtx_est_t ol;
  ldtx_pkg::ldtx_pd_t pdt;
  int errors = 0;
  int checked = 0;
  logic [5:0] idx_tab [6] = '{ldtx_pkg::IDX_SWING, ldtx_pkg::IDX_SHAPE,
    ldtx_pkg::IDX_CROSS, ldtx_pkg::IDX_BIAS_HI, ldtx_pkg::IDX_MON,
    ldtx_pkg::IDX_THRESH};

  always #4 clk_i = ~clk_i;

  ldtx_config_regs dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .bias_meas_i(meas), .photodiode_range_i(pd_rng),
    .swing_code_o(swing), .output_leg_select_o(leg),
    .drive_mode_select_o(mode), .deemph_delay_select_o(dly),
    .edge_rate_select_o(edge_r), .deemph_strength_o(strength),
    .crossing_shift_sign_o(sgn), .crossing_shift_magnitude_o(mag),
    .laser_bias_code_o(bias), .digital_pd_monitor_select_o(dpd),
    .digital_bias_monitor_select_o(dbm), .bias_fault_threshold_code_o(thr),
    .laser_bias_enable_o(lb_en), .bias_drive_on_o(drive_on),
    .bias_fault_o(fault), .open_loop_bias_ua_o(ol),
    .pd_target_na_o(pdt), .irq_o(irq)
  );

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic cycle; request held until ack is sampled, then released
  task automatic xfer(input logic w, input logic [5:0] idx,
                      input logic [7:0] d, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= {idx, 2'b00};
    wb_dat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    rd = rdat;
    check("ack", 32'(ack), 32'h00000001);
    check("ack wait", 32'(n), 32'h00000002);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] x;
    xfer(1'b1, idx, d, x);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
    logic [31:0] x;
    xfer(1'b0, idx, 8'h00, x);
    check($sformatf("reg %h", idx), x, {24'h000000, exp});
  endtask

  task automatic t_reset;
    foreach (idx_tab[i]) rd_chk(idx_tab[i], 8'h00);
    rd_chk(ldtx_pkg::IDX_CTRL, 8'h00);
    rd_chk(ldtx_pkg::IDX_MASK, 8'h00);
    rd_chk(ldtx_pkg::IDX_STATUS, 8'h00);
    check("irq", 32'(irq), 32'h00000000);
  endtask

  // Both polarities of every bit of the six table registers, reserved ones included
  task automatic t_fields;
    logic [7:0] v [6];
    logic [31:0] c, u;
    for (int p = 0; p < 2; p++) begin
      foreach (v[i]) begin
        v[i] = 8'ha5 + 8'(i);
        if (p == 1) v[i] = ~v[i];
        wr(idx_tab[i], v[i]);
      end
      foreach (v[i]) rd_chk(idx_tab[i], v[i]);
      check("swing", 32'(swing), 32'(v[0]));
      check("leg", 32'(leg), 32'(v[1][7]));
      check("mode", 32'(mode), 32'(v[1][6]));
      check("delay", 32'(dly), 32'(v[1][5]));
      check("strength", 32'(strength), 32'(v[1][3:0]));
      check("edge", 32'(edge_r), 32'(v[1][4]));
      check("cross", 32'({sgn, mag}), 32'(v[2]));
      c = 32'({v[3], v[4][1:0]});
      check("bias", 32'(bias), c);
      check("pdmon", 32'(dpd), 32'(v[4][6]));
      check("biasmon", 32'(dbm), 32'(v[4][5]));
      check("thresh", 32'(thr), 32'(v[5]));
      @(posedge clk_i);
      check("open", 32'(ol), c * ldtx_pkg::OPEN_LOOP_UA_PER_CODE);
      for (int r = 0; r < 4; r++) begin
        pd_rng <= 2'(r);
        u = (r == 0) ? ldtx_pkg::PD_UNIT_NA_LOW :
            (r == 1) ? ldtx_pkg::PD_UNIT_NA_MID : ldtx_pkg::PD_UNIT_NA_HIGH;
        repeat (2) @(posedge clk_i);
        check("pd", 32'(pdt), c * u);
      end
    end
  endtask

  // Disabled lane and unmapped place must leave state alone
  task automatic t_unmapped;
    wb_sel <= 4'he;
    wr(ldtx_pkg::IDX_SWING, 8'h3c);
    wb_sel <= 4'hf;
    rd_chk(ldtx_pkg::IDX_SWING, 8'h5a);
    wr(6'h05, 8'hff);
    rd_chk(6'h05, 8'h00);
  endtask

  task automatic t_irq;
    rd_chk(ldtx_pkg::IDX_STATUS, 8'h02);
    wr(ldtx_pkg::IDX_MASK, 8'h02);
    wr(ldtx_pkg::IDX_THRESH, 8'h40);
    check("irq set", 32'(irq), 32'h00000001);
    rd_chk(ldtx_pkg::IDX_STATUS, 8'h02);
    check("irq clr", 32'(irq), 32'h00000000);
    wr(ldtx_pkg::IDX_MASK, 8'h00);
    wr(ldtx_pkg::IDX_MON, 8'h20);
    check("irq mask", 32'(irq), 32'h00000000);
    rd_chk(ldtx_pkg::IDX_STATUS, 8'h02);
  endtask

  task automatic t_fault;
    int n;
    wr(ldtx_pkg::IDX_MASK, 8'h01);
    wr(ldtx_pkg::IDX_CTRL, 8'h01);
    check("enable", 32'(lb_en), 32'h00000001);
    meas <= 8'h3f;
    repeat (6) @(posedge clk_i);
    check("below", 32'(fault), 32'h00000000);
    check("drive", 32'(drive_on), 32'h00000001);
    meas <= 8'h40;
    n = 0;
    while (fault !== 1'b1 && n < 8) begin
      @(posedge clk_i);
      n++;
    end
    check("trip", 32'(fault), 32'h00000001);
    check("drive off", 32'(drive_on), 32'h00000000);
    check("irq fault", 32'(irq), 32'h00000001);
    rd_chk(ldtx_pkg::IDX_CTRL, 8'h81);
    meas <= 8'h00;
    rd_chk(ldtx_pkg::IDX_STATUS, 8'h01);
    check("irq off", 32'(irq), 32'h00000000);
    wr(ldtx_pkg::IDX_CTRL, 8'h00);
    check("disable", 32'(lb_en), 32'h00000000);
    @(posedge clk_i);
    check("cleared", 32'(fault), 32'h00000000);
    wr(ldtx_pkg::IDX_CTRL, 8'h01);
    @(posedge clk_i);
    check("rearmed", 32'(drive_on), 32'h00000001);
    // Analog monitoring selected: threshold is not in charge
    wr(ldtx_pkg::IDX_MON, 8'h00);
    meas <= 8'hff;
    repeat (6) @(posedge clk_i);
    check("analog", 32'(fault), 32'h00000000);
  endtask

  // Reset in mid-run must bring every register back to zero
  task automatic t_rerst;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    check("rst drive", 32'(drive_on), 32'h00000000);
    check("rst fault", 32'(fault), 32'h00000000);
    check("rst irq", 32'(irq), 32'h00000000);
    t_reset;
  endtask

  task automatic tally_and_finish;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_fields;
    t_unmapped;
    t_irq;
    t_fault;
    t_rerst;
    tally_and_finish;
  end

  // Whole run takes well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    tally_and_finish;
  end
endmodule

//--- verilog/ldtx_config_regs.sv
// TX configuration register bank of the laser driver on classic Wishbone
`timescale 1ns/100ps
module ldtx_config_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ldtx_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ldtx_pkg::DATA_W-1:0] wb_dat_i,
  output logic [ldtx_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog side
  input wire logic [7:0] bias_meas_i,
  input wire logic [1:0] photodiode_range_i,
  // Driver controls
  output logic [7:0] swing_code_o,
  output logic output_leg_select_o,
  output logic drive_mode_select_o,
  output logic deemph_delay_select_o,
  output logic edge_rate_select_o,
  output logic [ldtx_pkg::STRENGTH_W-1:0] deemph_strength_o,
  output logic crossing_shift_sign_o,
  output logic [ldtx_pkg::SHIFT_MAG_W-1:0] crossing_shift_magnitude_o,
  output logic [ldtx_pkg::BIAS_W-1:0] laser_bias_code_o,
  output logic digital_pd_monitor_select_o,
  output logic digital_bias_monitor_select_o,
  output logic [7:0] bias_fault_threshold_code_o,
  output logic laser_bias_enable_o,
  output logic bias_drive_on_o,
  output logic bias_fault_o,
  output ldtx_pkg::ldtx_est_t open_loop_bias_ua_o,
  output ldtx_pkg::ldtx_pd_t pd_target_na_o,
  output logic irq_o
);

  logic [7:0] swing_q;
  logic [7:0] shape_q;
  logic [7:0] cross_q;
  logic [7:0] bias_hi_q;
  logic [7:0] mon_q;
  logic [7:0] thresh_q;
  logic bias_en_q;
  logic [ldtx_pkg::EVT_W-1:0] status_q;
  logic [ldtx_pkg::EVT_W-1:0] status_d;
  logic [ldtx_pkg::EVT_W-1:0] mask_q;
  logic [ldtx_pkg::EVT_W-1:0] events;
  logic ack_q;
  logic [ldtx_pkg::DATA_W-1:0] rdata_q;
  logic [7:0] rdata_d;
  ldtx_pkg::ldtx_est_t est_q;
  ldtx_pkg::ldtx_pd_t pd_q;
  ldtx_pkg::ldtx_pd_t pd_unit;
  logic [5:0] idx;
  logic req;
  logic wr;
  logic rd;
  logic cfg_wr;
  logic fault;
  logic fault_set;
  logic [ldtx_pkg::BIAS_W-1:0] bias_code;

  assign idx = wb_adr_i[ldtx_pkg::ADDR_W-1:2];
  // A new request is taken only while no answer is standing
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  // Writes land in the low byte lane; other lanes hold nothing
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign rd = req && !wb_we_i;

  // Bus answer: one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Table registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      swing_q <= ldtx_pkg::REG_RESET;
      shape_q <= ldtx_pkg::REG_RESET;
      cross_q <= ldtx_pkg::REG_RESET;
      bias_hi_q <= ldtx_pkg::REG_RESET;
      mon_q <= ldtx_pkg::REG_RESET;
      thresh_q <= ldtx_pkg::REG_RESET;
    end else if (wr) begin
      case (idx)
        ldtx_pkg::IDX_SWING: swing_q <= wb_dat_i[7:0];
        ldtx_pkg::IDX_SHAPE: shape_q <= wb_dat_i[7:0];
        ldtx_pkg::IDX_CROSS: cross_q <= wb_dat_i[7:0];
        ldtx_pkg::IDX_BIAS_HI: bias_hi_q <= wb_dat_i[7:0];
        // Reserved bits are kept too, so they read back as written
        ldtx_pkg::IDX_MON: mon_q <= wb_dat_i[7:0];
        ldtx_pkg::IDX_THRESH: thresh_q <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // Control and mask registers: bias enable, toggled by software to clear faults
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bias_en_q <= 1'b0;
      mask_q <= '0;
    end else if (wr && idx == ldtx_pkg::IDX_CTRL) begin
      bias_en_q <= wb_dat_i[ldtx_pkg::CTRL_EN_BIT];
    end else if (wr && idx == ldtx_pkg::IDX_MASK) begin
      mask_q <= wb_dat_i[ldtx_pkg::EVT_W-1:0];
    end
  end

  assign cfg_wr = wr && (idx >= ldtx_pkg::IDX_SWING) &&
                  (idx <= ldtx_pkg::IDX_THRESH);

  always_comb begin
    events = '0;
    events[ldtx_pkg::EVT_FAULT_BIT] = fault_set;
    events[ldtx_pkg::EVT_CFG_BIT] = cfg_wr;
  end

  // Read clears the status, but an event in the same cycle survives
  always_comb begin
    status_d = status_q;
    if (rd && idx == ldtx_pkg::IDX_STATUS) begin
      status_d = '0;
    end
    status_d = status_d | events;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  assign irq_o = |(status_q & mask_q);

  // Read multiplexer
  always_comb begin
    rdata_d = 8'h00;
    case (idx)
      ldtx_pkg::IDX_SWING: rdata_d = swing_q;
      ldtx_pkg::IDX_SHAPE: rdata_d = shape_q;
      ldtx_pkg::IDX_CROSS: rdata_d = cross_q;
      ldtx_pkg::IDX_BIAS_HI: rdata_d = bias_hi_q;
      ldtx_pkg::IDX_MON: rdata_d = mon_q;
      ldtx_pkg::IDX_THRESH: rdata_d = thresh_q;
      ldtx_pkg::IDX_CTRL: begin
        rdata_d[ldtx_pkg::CTRL_EN_BIT] = bias_en_q;
        rdata_d[ldtx_pkg::CTRL_FAULT_BIT] = fault;
      end
      ldtx_pkg::IDX_STATUS: rdata_d[ldtx_pkg::EVT_W-1:0] = status_q;
      ldtx_pkg::IDX_MASK: rdata_d[ldtx_pkg::EVT_W-1:0] = mask_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else if (rd) begin
      rdata_q <= {24'h000000, rdata_d};
    end else if (req) begin
      rdata_q <= '0;
    end
  end

  assign wb_dat_o = rdata_q;
  assign wb_ack_o = ack_q;

  // Field fan-out to the driver
  assign swing_code_o = swing_q;
  assign output_leg_select_o = shape_q[ldtx_pkg::LEG_BIT];
  assign drive_mode_select_o = shape_q[ldtx_pkg::MODE_BIT];
  assign deemph_delay_select_o = shape_q[ldtx_pkg::DELAY_BIT];
  assign edge_rate_select_o = shape_q[ldtx_pkg::EDGE_BIT];
  assign deemph_strength_o = shape_q[ldtx_pkg::STRENGTH_W-1:0];
  assign crossing_shift_sign_o = cross_q[ldtx_pkg::SHIFT_SIGN_BIT];
  assign crossing_shift_magnitude_o =
    cross_q[ldtx_pkg::SHIFT_MAG_W-1:0];
  assign bias_code = {bias_hi_q, mon_q[ldtx_pkg::BIAS_LO_W-1:0]};
  assign laser_bias_code_o = bias_code;
  assign digital_pd_monitor_select_o = mon_q[ldtx_pkg::PD_MON_BIT];
  assign digital_bias_monitor_select_o =
    mon_q[ldtx_pkg::BIAS_MON_BIT];
  assign bias_fault_threshold_code_o = thresh_q;
  assign laser_bias_enable_o = bias_en_q;
  // A latched fault holds the bias off until software toggles enable
  assign bias_drive_on_o = bias_en_q && !fault;
  assign bias_fault_o = fault;

  // Photodiode current unit by range; 1x shares the top unit
  always_comb begin
    case (photodiode_range_i)
      2'b00: pd_unit = ldtx_pkg::ldtx_pd_t'(ldtx_pkg::PD_UNIT_NA_LOW);
      2'b01: pd_unit = ldtx_pkg::ldtx_pd_t'(ldtx_pkg::PD_UNIT_NA_MID);
      default: pd_unit = ldtx_pkg::ldtx_pd_t'(ldtx_pkg::PD_UNIT_NA_HIGH);
    endcase
  end

  // Digital estimates of the analog set points; the 150 mA ceiling
  // depends on the coupling ratio and is the analog loop's concern
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      est_q <= '0;
      pd_q <= '0;
    end else begin
      est_q <= ldtx_pkg::ldtx_est_t'(bias_code) *
               ldtx_pkg::ldtx_est_t'(ldtx_pkg::OPEN_LOOP_UA_PER_CODE);
      pd_q <= ldtx_pkg::ldtx_pd_t'(bias_code) * pd_unit;
    end
  end

  assign open_loop_bias_ua_o = est_q;
  assign pd_target_na_o = pd_q;

  ldtx_fault_mon u_fault (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bias_meas_i(bias_meas_i),
    .threshold_i(thresh_q),
    .digital_mon_i(mon_q[ldtx_pkg::BIAS_MON_BIT]),
    .laser_bias_enable_i(bias_en_q),
    .fault_o(fault),
    .fault_set_o(fault_set)
  );

  chk_ack_single: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  chk_swing_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr && idx == ldtx_pkg::IDX_SWING |=>
      swing_code_o == $past(wb_dat_i[7:0]) && wb_ack_o)
    else $error("swing code not taken from write");

  chk_leg_mode: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr && idx == ldtx_pkg::IDX_SHAPE |=>
      output_leg_select_o == $past(wb_dat_i[7]) &&
      drive_mode_select_o == $past(wb_dat_i[6]))
    else $error("leg or mode select wrong after write");

  chk_deemph_fields: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr && idx == ldtx_pkg::IDX_SHAPE |=>
      deemph_delay_select_o == $past(wb_dat_i[5]) &&
      edge_rate_select_o == $past(wb_dat_i[4]) &&
      deemph_strength_o == $past(wb_dat_i[3:0]))
    else $error("de-emphasis or edge fields wrong after write");

  chk_cross_fields: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr && idx == ldtx_pkg::IDX_CROSS |=>
      {crossing_shift_sign_o, crossing_shift_magnitude_o} ==
      $past(wb_dat_i[7:0]))
    else $error("cross-point fields wrong after write");

  chk_bias_join: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr && idx == ldtx_pkg::IDX_MON |=>
      laser_bias_code_o[1:0] == $past(wb_dat_i[1:0]) &&
      digital_bias_monitor_select_o == $past(wb_dat_i[5]) &&
      digital_pd_monitor_select_o == $past(wb_dat_i[6]))
    else $error("monitor fields or bias low bits wrong");

  chk_open_loop: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 open_loop_bias_ua_o ==
      18'(32'($past(laser_bias_code_o)) * ldtx_pkg::OPEN_LOOP_UA_PER_CODE))
    else $error("open-loop estimate wrong");

  chk_pd_range: assert property (
    @(posedge clk_i) disable iff (rst_i)
    photodiode_range_i == 2'b01 |=>
      pd_target_na_o ==
        22'(32'($past(laser_bias_code_o)) * ldtx_pkg::PD_UNIT_NA_MID))
    else $error("photodiode target wrong for middle range");

  chk_readback: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd && idx == ldtx_pkg::IDX_THRESH |=>
      wb_ack_o && wb_dat_o == {24'h000000, $past(thresh_q)})
    else $error("threshold read-back wrong");

  chk_status_sticky: assert property (
    @(posedge clk_i) disable iff (rst_i)
    fault_set |=> status_q[ldtx_pkg::EVT_FAULT_BIT])
    else $error("fault event lost in status");

  chk_bias_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    bias_fault_o |-> !bias_drive_on_o)
    else $error("bias drive on during fault");

  chk_status_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd && idx == ldtx_pkg::IDX_STATUS |=> status_q == $past(events))
    else $error("status not cleared by read");

  chk_bias_high: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr && idx == ldtx_pkg::IDX_BIAS_HI |=>
      laser_bias_code_o[9:2] == $past(wb_dat_i[7:0]))
    else $error("bias high bits not taken from write");

  chk_thresh_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr && idx == ldtx_pkg::IDX_THRESH |=>
      bias_fault_threshold_code_o == $past(wb_dat_i[7:0]))
    else $error("threshold not taken from write");

  chk_lane_drop: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req && wb_we_i && !wb_sel_i[0] |=>
      $stable(swing_q) && $stable(shape_q) && $stable(mon_q) &&
      $stable(thresh_q) && $stable(bias_en_q))
    else $error("write with low lane disabled changed state");

  chk_reset_clear: assert property (
    @(posedge clk_i)
    rst_i |=> {swing_q, shape_q, cross_q} == 24'h000000 &&
      {bias_hi_q, mon_q, thresh_q} == 24'h000000 && !wb_ack_o)
    else $error("registers not cleared by reset");

endmodule

//--- verilog/ldtx_fault_mon.sv
// Bias-fault detector with latched fault and enable-toggle clear
`timescale 1ns/100ps
module ldtx_fault_mon (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] bias_meas_i,
  input wire logic [7:0] threshold_i,
  input wire logic digital_mon_i,
  input wire logic laser_bias_enable_i,
  output logic fault_o,
  output logic fault_set_o
);

  logic [7:0] meas_s1_q;
  logic [7:0] meas_s2_q;
  logic fault_q;
  logic trip;

  // Measurement arrives from the analog side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meas_s1_q <= 8'h00;
      meas_s2_q <= 8'h00;
    end else begin
      meas_s1_q <= bias_meas_i;
      meas_s2_q <= meas_s1_q;
    end
  end

  assign trip = digital_mon_i && laser_bias_enable_i && !fault_q &&
                (meas_s2_q >= threshold_i);

  // Reset or a low enable releases the latch; setting needs enable high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_q <= 1'b0;
    end else if (!laser_bias_enable_i) begin
      fault_q <= 1'b0;
    end else if (trip) begin
      fault_q <= 1'b1;
    end
  end

  assign fault_o = fault_q;
  assign fault_set_o = trip;

  chk_fault_release: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !laser_bias_enable_i |=> !fault_q)
    else $error("fault not released by low enable");

  chk_fault_trip: assert property (
    @(posedge clk_i) disable iff (rst_i)
    trip |=> fault_q)
    else $error("fault not latched after trip");

endmodule

//--- verilog/ldtx_pkg.sv
// Package of offsets, field positions and constants of the TX config bank
package ldtx_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_SWING = 6'h0c;
  localparam logic [5:0] IDX_SHAPE = 6'h0d;
  localparam logic [5:0] IDX_CROSS = 6'h0e;
  localparam logic [5:0] IDX_BIAS_HI = 6'h0f;
  localparam logic [5:0] IDX_MON = 6'h10;
  localparam logic [5:0] IDX_THRESH = 6'h11;
  localparam logic [5:0] IDX_CTRL = 6'h18;
  localparam logic [5:0] IDX_STATUS = 6'h19;
  localparam logic [5:0] IDX_MASK = 6'h1a;

  // Values after reset
  localparam logic [7:0] REG_RESET = 8'h00;

  // Output shape register fields
  localparam int unsigned LEG_BIT = 7;
  localparam int unsigned MODE_BIT = 6;
  localparam int unsigned DELAY_BIT = 5;
  localparam int unsigned EDGE_BIT = 4;
  localparam int unsigned STRENGTH_W = 4;

  // Cross-point register fields
  localparam int unsigned SHIFT_SIGN_BIT = 7;
  localparam int unsigned SHIFT_MAG_W = 7;

  // Monitor register fields
  localparam int unsigned PD_MON_BIT = 6;
  localparam int unsigned BIAS_MON_BIT = 5;
  localparam int unsigned BIAS_LO_W = 2;
  localparam int unsigned BIAS_W = 10;

  // Control and event registers
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_FAULT_BIT = 7;
  localparam int unsigned EVT_W = 2;
  localparam int unsigned EVT_FAULT_BIT = 0;
  localparam int unsigned EVT_CFG_BIT = 1;

  // Analog scale figures
  localparam int unsigned SWING_SPAN_MVPP = 2400;
  localparam int unsigned SWING_STEP_UVPP = 9500;
  localparam int unsigned OPEN_LOOP_UA_PER_CODE = 147;
  localparam int unsigned PD_UNIT_NA_LOW = 750;
  localparam int unsigned PD_UNIT_NA_MID = 1500;
  localparam int unsigned PD_UNIT_NA_HIGH = 3000;
  localparam int unsigned BIAS_CAP_MA = 150;

  typedef logic [17:0] ldtx_est_t;
  typedef logic [21:0] ldtx_pd_t;

endpackage
